//--- dv/mdpl_host_model.sv
// Behavioural monitor-and-control computer on the multidrop bus
`timescale 1ns/1ps
`default_nettype none

module mdpl_host_model
  import mdpl_pkg::*;
#(
  parameter int BIT_LEN = BIT_CLKS_I
) (
  input wire logic i_clk_sys,
  input wire logic i_txd,
  input wire logic i_tx_oe,
  output logic o_rxd
);
  logic [7:0] rx_q[$];
  logic line;

  // ==========================================================
  // Released transmitter leaves the pulled-up bus at mark
  assign line = i_tx_oe ? i_txd : 1'b1;

  initial o_rxd = 1'b1;

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : tick

  // ==========================================================
  // One character: start, data, two marks, then idle at mark
  task automatic send_byte(input logic [7:0] b);
    o_rxd <= 1'b0;
    tick(BIT_LEN);
    for (int k = 0; k < 8; k++)
    begin
      o_rxd <= b[k];
      tick(BIT_LEN);
    end
    o_rxd <= 1'b1;
    tick(2 * BIT_LEN);
  endtask : send_byte

  task automatic send_frame(input logic [7:0] q[$]);
    foreach (q[j]) send_byte(q[j]);
  endtask : send_frame

  // ==========================================================
  // Reply receiver, sampled at mid-bit
  initial
  begin
    logic [7:0] b;
    forever
    begin
      @(posedge i_clk_sys);
      if (line === 1'b0)
      begin
        tick(BIT_LEN / 2);
        for (int k = 0; k < 8; k++)
        begin
          tick(BIT_LEN);
          b[k] = line;
        end
        tick(BIT_LEN);
        if (line === 1'b1) rx_q.push_back(b);
      end
    end
  end
endmodule : mdpl_host_model
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the multidrop packet link
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      fails++; \
      $display("mismatch %s expected %h seen %h", nm, ex, got); \
    end \
  end

module testbench
  import mdpl_pkg::*;
;
  localparam logic [15:0] MAXD = 16'h0004;
  // Short bit period keeps the run brief
  localparam int BITL = 16;
  localparam int TIMEOUT = 60000;
  logic i_clk_sys = 1'b0;
  logic i_rst_n;
  logic rxd, txd, tx_oe, cmd_valid, data_valid, frame_bad, overrun;
  logic [7:0] own, data, last_src, last_fsn;
  logic [15:0] op;
  mdpl_cmd_s cmd;
  mdpl_cmd_s cmd_q[$];
  logic [7:0] data_q[$];
  logic [7:0] d2[$];
  logic [7:0] none[$];
  bit have_last;
  int fails, compares, cycles, oe_rises, bad_seen;

  mdpl_link #(
    .MAX_DATA(MAXD),
    .BIT_TOP(12'(BITL - 1)),
    .HALF_TOP(12'(BITL / 2 - 1))
  ) mdpl_link_inst (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_rxd(rxd), .i_own_addr(own),
    .o_txd(txd), .o_tx_oe(tx_oe), .o_cmd(cmd), .o_cmd_valid(cmd_valid),
    .o_data(data), .o_data_valid(data_valid), .o_frame_bad(frame_bad),
    .o_overrun(overrun)
  );

  mdpl_host_model #(.BIT_LEN(BITL)) mdpl_host_model_inst (
    .i_clk_sys(i_clk_sys), .i_txd(txd), .i_tx_oe(tx_oe), .o_rxd(rxd)
  );

  initial
  begin
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // ==========================================================
  // Output monitor and timeout
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cmd_valid === 1'b1) cmd_q.push_back(cmd);
    if (data_valid === 1'b1) data_q.push_back(data);
    if (frame_bad === 1'b1) bad_seen++;
    if ($rose(tx_oe)) oe_rises++;
    if (i_rst_n === 1'b1) `CHK("overrun", 1'b0, overrun)
    if (cycles > TIMEOUT)
    begin
      fails++;
      $display("mismatch timeout expected %0d seen %0d", TIMEOUT, cycles);
      conclude();
    end
  end

  // ==========================================================
  // Sends one frame and checks it against the reference model
  task automatic run_frame(input string nm, input logic [7:0] src, dst, fsn,
      input logic [7:0] d[$], input bit bad);
    logic [7:0] f[$];
    logic [7:0] r[$];
    int sum;
    bit mine, rep, acc;
    f = '{SYNC_CHAR, 8'h00, 8'(d.size()), src, dst, fsn, op[15:8], op[7:0]};
    f = {f, d};
    sum = 0;
    foreach (f[k]) if (k > 0) sum += f[k];
    f.push_back(8'(sum) ^ (bad ? 8'h01 : 8'h00));
    cmd_q.delete();
    data_q.delete();
    mdpl_host_model_inst.rx_q.delete();
    bad_seen = 0;
    oe_rises = 0;
    mdpl_host_model_inst.send_frame(f);
    mine = (dst == own);
    acc = !bad && (mine || dst == BCAST_ID) && d.size() <= MAXD;
    rep = acc && have_last && src == last_src && fsn == last_fsn;
    if (acc)
    begin
      have_last = 1;
      last_src = src;
      last_fsn = fsn;
    end
    if (acc && mine)
      for (int n = 0; n < 4000 && mdpl_host_model_inst.rx_q.size() < 9; n++)
        @(posedge i_clk_sys);
    else
      repeat (100) @(posedge i_clk_sys);
    `CHK({nm, " cmds"}, (acc && !rep) ? 1 : 0, cmd_q.size())
    if (cmd_q.size() == 1) `CHK({nm, " cmd"}, {op, src, dst, fsn, 16'(d.size())}, cmd_q[0])
    `CHK({nm, " data n"}, (acc && !rep && mine) ? d.size() : 0, data_q.size())
    foreach (data_q[k]) if (k < d.size()) `CHK({nm, " data"}, d[k], data_q[k])
    `CHK({nm, " bad"}, (bad && mine) ? 1 : 0, bad_seen)
    `CHK({nm, " replies"}, (acc && mine) ? 1 : 0, oe_rises)
    if (acc && mine)
    begin
      r = '{SYNC_CHAR, 8'h00, 8'h00, dst, src, fsn, GOOD_OPCODE[15:8], GOOD_OPCODE[7:0]};
      r.push_back(8'(dst + src + fsn));
      `CHK({nm, " reply n"}, 9, mdpl_host_model_inst.rx_q.size())
      foreach (mdpl_host_model_inst.rx_q[k])
        `CHK({nm, " reply"}, r[k], mdpl_host_model_inst.rx_q[k])
    end
    $display("test %s done", nm);
  endtask : run_frame

  // ==========================================================
  // Main sequence
  initial
  begin
    fails = 0;
    compares = 0;
    cycles = 0;
    have_last = 0;
    void'($urandom(32'hd145));
    i_rst_n = 1'b0;
    own = 8'(32 + $urandom % 223);
    op = 16'($urandom);
    d2 = '{8'($urandom), 8'($urandom)};
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    run_frame("good", 8'hff, own, 8'hff, d2, 0);
    run_frame("repeat", 8'hff, own, 8'hff, d2, 0);
    run_frame("wrap", 8'hff, own, 8'h00, d2, 0);
    run_frame("badsum", 8'hff, own, 8'h01, none, 1);
    run_frame("bcast", 8'hff, BCAST_ID, 8'h02, none, 0);
    run_frame("other", 8'hff, own ^ 8'h01, 8'h03, none, 0);
    run_frame("long", 8'hff, own, 8'h04, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
    conclude();
  end
endmodule : testbench
`default_nettype wire

//--- logic/mdpl_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module mdpl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;

  // Depth is a power of two; the extra pointer bit tells full from empty
  wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire empty = (wp_r == rp_r);
  wire wr_en = i_in_valid && !full;
  wire rd_en = i_out_ready && !empty;

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (wr_en)
        wp_r <= wp_r + (AW+1)'(1);
      if (rd_en)
        rp_r <= rp_r + (AW+1)'(1);
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (wr_en)
      mem_r[wp_r[AW-1:0]] <= i_in_data;
  end

endmodule : mdpl_fifo

`default_nettype wire

//--- logic/mdpl_link.sv
// Multidrop packet link: byte receiver, packet parser, acknowledgement sender
//
// Behaviour
// - Bytes go out and come in least significant bit first.
// - Each character: eight data bits, then two mark stop bits.
// - Line idles at mark; a space after the stops is a start bit.
// - Every packet begins with sync byte 16h.
// - Fields: sync, count(2), sender, target, sequence, opcode(2), data, checksum.
// - Byte count gives the number of data bytes before the checksum.
// - Opcode is two bytes: message type or response code.
// - Checksum is eight-bit sum of all bytes after sync.
// - Wait for sync, load frame; checksum mismatch discards and resyncs. Data bytes still reach o_data before the check.
// - Sender address is the originator; target address is the recipient.
// - Sequence number is eight bits and wraps from 255 to zero.
// - Repeated number from same sender: do not execute, still acknowledge.
// - Reply swaps sender and target addresses and carries a response code.
// - Opcode is passed on as action class or query code.
// - Valid addressed message gets a reply with opcode zero.
// - Unit addresses lie in 32 to 255; 255 is the computer.
// - Broadcast target is accepted by all and never answered.
`timescale 1ns/1ps
`default_nettype none

module mdpl_link
  import mdpl_pkg::*;
#(
  parameter logic [15:0] MAX_DATA = MAX_DATA_DEF,
  // Bit period and half bit period, less one, in clocks
  parameter logic [11:0] BIT_TOP = BIT_CLKS,
  parameter logic [11:0] HALF_TOP = HALF_CLKS
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_rxd,
  input wire logic [7:0] i_own_addr,
  output logic o_txd,
  output logic o_tx_oe,
  output mdpl_cmd_s o_cmd,
  output logic o_cmd_valid,
  output logic [7:0] o_data,
  output logic o_data_valid,
  output logic o_frame_bad,
  output logic o_overrun
);

  // ==========================================================
  // Functions
  function automatic logic [10:0] char_frame(input logic [7:0] b);
    char_frame = {2'b11, b, 1'b0};
  endfunction : char_frame

  function automatic logic [7:0] resp_byte(
    input logic [3:0] idx,
    input logic [7:0] s,
    input logic [7:0] d,
    input logic [7:0] f
  );
    case (idx)
      4'h0: resp_byte = SYNC_CHAR;
      4'h1: resp_byte = 8'h00;
      4'h2: resp_byte = 8'h00;
      4'h3: resp_byte = s;
      4'h4: resp_byte = d;
      4'h5: resp_byte = f;
      4'h6: resp_byte = GOOD_OPCODE[15:8];
      4'h7: resp_byte = GOOD_OPCODE[7:0];
      default: resp_byte = 8'(s + d + f + GOOD_OPCODE[15:8] + GOOD_OPCODE[7:0]);
    endcase
  endfunction : resp_byte

  // ==========================================================
  // Byte receiver
  mdpl_rx_e rx_st_r;
  logic [11:0] rx_cnt_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_push_r;
  logic fifo_in_ready;

  wire rx_tick = (rx_cnt_r == 12'h000);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      rx_st_r <= R_IDLE;
      rx_cnt_r <= 12'h000;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_push_r <= 1'b0;
    end
    else
    begin
      rx_push_r <= 1'b0;
      rx_cnt_r <= rx_tick ? BIT_TOP : rx_cnt_r - 12'h001;
      case (rx_st_r)
        R_IDLE:
          if (!i_rxd)
          begin
            rx_st_r <= R_START;
            rx_cnt_r <= HALF_TOP;
          end
        R_START:
          if (rx_tick)
          begin
            rx_st_r <= i_rxd ? R_IDLE : R_DATA;
            rx_bit_r <= 4'h0;
          end
        R_DATA:
          if (rx_tick)
          begin
            rx_sh_r <= {i_rxd, rx_sh_r[7:1]};
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_bit_r == RX_BITS - 4'h1)
              rx_st_r <= R_STOP;
          end
        R_STOP:
          if (rx_tick)
          begin
            rx_st_r <= R_IDLE;
            rx_push_r <= i_rxd;
          end
        default: rx_st_r <= R_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Receive buffer; drained by the parser, stalled while replying
  logic fb_valid;
  logic [7:0] fb_data;
  logic tx_busy_r;

  wire take = fb_valid && !tx_busy_r;

  mdpl_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_in_valid(rx_push_r),
    .o_in_ready(fifo_in_ready),
    .i_in_data(rx_sh_r),
    .o_out_valid(fb_valid),
    .i_out_ready(!tx_busy_r),
    .o_out_data(fb_data)
  );

  // ==========================================================
  // Packet parser
  mdpl_pst_e pst_r;
  mdpl_pst_e pst_nxt;
  logic [15:0] cnt_r;
  logic [15:0] left_r;
  logic [7:0] src_r;
  logic [7:0] dst_r;
  logic [7:0] fsn_r;
  logic [15:0] op_r;
  logic [7:0] sum_r;
  logic hit_r;
  logic dup_r;
  logic [7:0] last_src_r;
  logic [7:0] last_fsn_r;
  logic last_ok_r;

  wire [15:0] cnt_full = {cnt_r[15:8], fb_data};
  wire too_long = (cnt_full > MAX_DATA);
  wire sum_ok = (fb_data == sum_r);
  wire hit_w = (fb_data == i_own_addr) || (fb_data == BCAST_ID);
  wire dup_w = last_ok_r && (src_r == last_src_r) && (fb_data == last_fsn_r);
  wire frame_done = take && (pst_r == P_SUM);
  wire good_end = frame_done && sum_ok && hit_r;
  wire reply_go = good_end && (dst_r != BCAST_ID);
  wire at_data = take && (pst_r == P_DATA);

  always_comb
  begin
    pst_nxt = pst_r;
    if (take)
    begin
      case (pst_r)
        P_SYNC:
          if (fb_data == SYNC_CHAR)
            pst_nxt = P_CNT_HI;
        P_CNT_HI: pst_nxt = P_CNT_LO;
        P_CNT_LO: pst_nxt = too_long ? P_SYNC : P_SRC;
        P_SRC: pst_nxt = P_DST;
        P_DST: pst_nxt = P_FSN;
        P_FSN: pst_nxt = P_OP_HI;
        P_OP_HI: pst_nxt = P_OP_LO;
        P_OP_LO: pst_nxt = (cnt_r == 16'h0000) ? P_SUM : P_DATA;
        P_DATA:
          if (left_r == 16'h0001)
            pst_nxt = P_SUM;
        P_SUM: pst_nxt = P_SYNC;
        default: pst_nxt = P_SYNC;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      pst_r <= P_SYNC;
      cnt_r <= 16'h0000;
      left_r <= 16'h0000;
      src_r <= 8'h00;
      dst_r <= 8'h00;
      fsn_r <= 8'h00;
      op_r <= 16'h0000;
      sum_r <= 8'h00;
      hit_r <= 1'b0;
      dup_r <= 1'b0;
    end
    else
    begin
      pst_r <= pst_nxt;
      if (take)
        sum_r <= (pst_r == P_SYNC) ? 8'h00 : sum_r + fb_data;
      if (take && pst_r == P_CNT_HI)
        cnt_r <= {fb_data, 8'h00};
      if (take && pst_r == P_CNT_LO)
      begin
        cnt_r <= cnt_full;
        left_r <= cnt_full;
      end
      if (at_data)
        left_r <= left_r - 16'h0001;
      if (take && pst_r == P_SRC)
        src_r <= fb_data;
      if (take && pst_r == P_DST)
      begin
        dst_r <= fb_data;
        hit_r <= hit_w;
      end
      if (take && pst_r == P_FSN)
      begin
        fsn_r <= fb_data;
        dup_r <= dup_w;
      end
      if (take && pst_r == P_OP_HI)
        op_r <= {fb_data, 8'h00};
      if (take && pst_r == P_OP_LO)
        op_r <= {op_r[15:8], fb_data};
    end
  end

  // Last accepted sender and sequence number, for repeat detection
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      last_src_r <= 8'h00;
      last_fsn_r <= 8'h00;
      last_ok_r <= 1'b0;
    end
    else if (good_end)
    begin
      last_src_r <= src_r;
      last_fsn_r <= fsn_r;
      last_ok_r <= 1'b1;
    end
  end

  // ==========================================================
  // User-side outputs
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      o_cmd <= '0;
      o_cmd_valid <= 1'b0;
      o_data <= 8'h00;
      o_data_valid <= 1'b0;
      o_frame_bad <= 1'b0;
      o_overrun <= 1'b0;
    end
    else
    begin
      o_cmd_valid <= good_end && !dup_r;
      if (good_end && !dup_r)
        o_cmd <= '{op_r, src_r, dst_r, fsn_r, cnt_r};
      o_data_valid <= at_data && hit_r && !dup_r;
      o_data <= fb_data;
      o_frame_bad <= frame_done && hit_r && !sum_ok;
      o_overrun <= rx_push_r && !fifo_in_ready;
    end
  end

  // ==========================================================
  // Acknowledgement sender
  logic [3:0] tx_idx_r;
  logic [3:0] tx_bit_r;
  logic [11:0] tx_cnt_r;
  logic [10:0] tx_sh_r;
  logic [7:0] resp_src_r;
  logic [7:0] resp_dst_r;
  logic [7:0] resp_fsn_r;

  wire tx_tick = (tx_cnt_r == 12'h000);
  wire [3:0] tx_idx_nxt = tx_idx_r + 4'h1;
  wire [7:0] next_byte = resp_byte(tx_idx_nxt, resp_src_r, resp_dst_r, resp_fsn_r);

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      resp_src_r <= 8'h00;
      resp_dst_r <= 8'h00;
      resp_fsn_r <= 8'h00;
    end
    else if (reply_go)
    begin
      resp_src_r <= dst_r;
      resp_dst_r <= src_r;
      resp_fsn_r <= fsn_r;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      tx_busy_r <= 1'b0;
      o_tx_oe <= 1'b0;
      o_txd <= 1'b1;
      tx_idx_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_cnt_r <= 12'h000;
      tx_sh_r <= 11'h7ff;
    end
    else if (reply_go)
    begin
      tx_busy_r <= 1'b1;
      o_tx_oe <= 1'b1;
      tx_idx_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_cnt_r <= 12'h000;
      tx_sh_r <= char_frame(SYNC_CHAR);
    end
    else if (tx_busy_r)
    begin
      tx_cnt_r <= tx_tick ? BIT_TOP : tx_cnt_r - 12'h001;
      if (tx_tick)
      begin
        if (tx_bit_r != CHAR_BITS)
        begin
          o_txd <= tx_sh_r[0];
          tx_sh_r <= {1'b1, tx_sh_r[10:1]};
          tx_bit_r <= tx_bit_r + 4'h1;
        end
        else if (tx_idx_r == RESP_LAST)
        begin
          tx_busy_r <= 1'b0;
          o_tx_oe <= 1'b0;
        end
        else
        begin
          tx_idx_r <= tx_idx_nxt;
          tx_bit_r <= 4'h0;
          tx_cnt_r <= 12'h000;
          tx_sh_r <= char_frame(next_byte);
        end
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  a_idle_mark: assert property (!o_tx_oe |-> o_txd)
    else $error("Line not at mark while released");
  a_sync_lead: assert property ($rose(o_tx_oe) |-> tx_sh_r == char_frame(SYNC_CHAR))
    else $error("Reply does not open with sync");
  a_stop_bits: assert property (tx_busy_r && tx_bit_r >= STOP_FIRST |-> o_txd)
    else $error("Stop bit not at mark");
  a_lsb_first: assert property (rx_st_r == R_DATA && rx_tick |=> rx_sh_r[7] == $past(i_rxd))
    else $error("Received bit not shifted in from the top");
  a_bad_drop: assert property (frame_done && !sum_ok |=> pst_r == P_SYNC && !o_cmd_valid && !o_tx_oe)
    else $error("Bad checksum frame not discarded");
  a_bcast_quiet: assert property (good_end && dst_r == BCAST_ID |=> !o_tx_oe [*2])
    else $error("Broadcast frame answered");
  a_miss_quiet: assert property (frame_done && !hit_r |=> !o_tx_oe && !o_cmd_valid)
    else $error("Frame for another target acted on");
  a_dup_ack: assert property (reply_go && dup_r |=> !o_cmd_valid && o_tx_oe)
    else $error("Repeat not acknowledged or executed again");
  a_swap_ids: assert property (reply_go |=> resp_src_r == $past(dst_r) && resp_dst_r == $past(src_r))
    else $error("Reply addresses not swapped");
  a_long_drop: assert property (take && pst_r == P_CNT_LO && too_long |=> pst_r == P_SYNC)
    else $error("Oversized frame not dropped");
  a_count_end: assert property (at_data && left_r == 16'h0001 |=> pst_r == P_SUM)
    else $error("Checksum not expected after last data byte");

  c_reply: cover property (reply_go ##1 o_tx_oe);
  c_dup: cover property (good_end && dup_r);
  c_bad: cover property (frame_done && hit_r && !sum_ok);
  c_full: cover property (!fifo_in_ready);

endmodule : mdpl_link

`default_nettype wire

//--- logic/mdpl_pkg.sv
// Shared constants, types and states for the multidrop packet link
package mdpl_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 20000000;
  localparam int BAUD_RATE = 9600;
  localparam int BIT_CLKS_I = CLK_HZ / BAUD_RATE;
  localparam logic [11:0] BIT_CLKS = 12'(BIT_CLKS_I - 1);
  localparam logic [11:0] HALF_CLKS = 12'(BIT_CLKS_I / 2 - 1);

  // ==========================================================
  // Character and packet layout
  localparam logic [3:0] RX_BITS = 4'h8;
  localparam logic [3:0] CHAR_BITS = 4'hb;
  localparam logic [3:0] STOP_FIRST = 4'ha;
  localparam logic [3:0] RESP_LAST = 4'h8;
  localparam logic [7:0] SYNC_CHAR = 8'h16;
  localparam logic [7:0] BCAST_ID = 8'h00;
  localparam logic [15:0] GOOD_OPCODE = 16'h0000;
  localparam logic [15:0] MAX_DATA_DEF = 16'h0020;

  // ==========================================================
  // Buffering
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 32;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [15:0] opcode;
    logic [7:0] sender_addr;
    logic [7:0] target_addr;
    logic [7:0] fsn;
    logic [15:0] count;
  } mdpl_cmd_s;

  typedef enum {R_IDLE, R_START, R_DATA, R_STOP} mdpl_rx_e;

  typedef enum {
    P_SYNC, P_CNT_HI, P_CNT_LO, P_SRC, P_DST,
    P_FSN, P_OP_HI, P_OP_LO, P_DATA, P_SUM
  } mdpl_pst_e;

endpackage : mdpl_pkg
